// >>> oism_pkg.sv
/*
 Constants, register map and types for the outbound interrupt source map.
 Assumes one clock, software access over a plain strobe port with byte addresses.
*/
package oism_pkg;
   // What this block does
   // R1 - Source 1 is the OR of every active and enabled flag of the 6G serdes hierarchy.
   // R2 - Source 2 is the OR of every active and enabled flag of the 10G serdes hierarchy.
   // R3 - The two external inputs drive sources 3 and 4, and source 5 stays low.
   // R4 - Peripheral requests sit on fixed sources 6 to 39, from card wake up to the DDR controller.
   // R5 - Sources 18 and 19 carry the mailbox soft interrupts and 40 to 49 the ten shared soft bits.
   // R6 - There are exactly two destinations, each driving its own external output pin.
   // R7 - Every source, event and indication inside the controller is active high.
   // R8 - Source polarity inversion is done before the controller sees the request.
   // R9 - Destination polarity inversion is done after the controller output, before the pin.
   // R10 - A flag is set while its source is high in level mode, or on any, falling or rising change.
   // R11 - Writing one clears a flag, and a still active level or a new event sets it again at once.
   // R12 - With bypass set the raw source is used and flag and trigger are ignored.
   // R13 - An enabled flagged source reaches a destination only when its mask bit is set.
   // R14 - Each destination is the registered OR of value, enable and mask over all sources.
   // R15 - Unassigned sources read as zero and never reach a destination.

   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int NSRC = 50;
   localparam int HIER_N = 8;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int HI_W = NSRC - DATA_W;

   // ----------------------------------------
   // Source positions
   // ----------------------------------------
   localparam int SRC_S6 = 1;
   localparam int SRC_S10 = 2;
   localparam int SRC_EXT0 = 3;
   localparam int SRC_EXT1 = 4;
   localparam int SRC_RSVD = 5;
   localparam int SRC_WDOG = 8;
   localparam int SRC_MBOX0 = 18;
   localparam int SRC_DDR = 39;
   localparam int SRC_SOFT_LO = 40;
   localparam logic [NSRC-1:0] SRC_USED = 50'h3_ffef_ffff_ffdf;

   // ----------------------------------------
   // Trigger codes
   // ----------------------------------------
   localparam logic [1:0] TRIG_LEVEL = 2'h0;
   localparam logic [1:0] TRIG_ANY = 2'h1;
   localparam logic [1:0] TRIG_FALL = 2'h2;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [ADDR_W-1:0] PAIR_MASK = 8'hf8;
   localparam logic [ADDR_W-1:0] WORD_MASK = 8'hfc;
   localparam int HI_BIT = 2;
   localparam logic [ADDR_W-1:0] OFF_RAW = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_BYP = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_TRIG0 = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_TRIG1 = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_FORCE = 8'h20;
   localparam logic [ADDR_W-1:0] OFF_STICKY = 8'h28;
   localparam logic [ADDR_W-1:0] OFF_ENA = 8'h30;
   localparam logic [ADDR_W-1:0] OFF_IDENT = 8'h38;
   localparam logic [ADDR_W-1:0] OFF_MAP0 = 8'h40;
   localparam logic [ADDR_W-1:0] OFF_MAP1 = 8'h48;
   localparam logic [ADDR_W-1:0] OFF_DID0 = 8'h50;
   localparam logic [ADDR_W-1:0] OFF_DID1 = 8'h58;
   localparam logic [ADDR_W-1:0] HREG_MASK = 8'hc0;
   localparam logic [ADDR_W-1:0] HREG_BASE = 8'h80;
   localparam logic [ADDR_W-1:0] HFIELD_MASK = 8'h1c;
   localparam int HIDX_BIT = 5;
   localparam logic [ADDR_W-1:0] HOFF_POL = 8'h00;
   localparam logic [ADDR_W-1:0] HOFF_RAW = 8'h04;
   localparam logic [ADDR_W-1:0] HOFF_BYP = 8'h08;
   localparam logic [ADDR_W-1:0] HOFF_TRIG0 = 8'h0c;
   localparam logic [ADDR_W-1:0] HOFF_TRIG1 = 8'h10;
   localparam logic [ADDR_W-1:0] HOFF_STICKY = 8'h14;
   localparam logic [ADDR_W-1:0] HOFF_ENA = 8'h18;
   localparam logic [ADDR_W-1:0] HOFF_IDENT = 8'h1c;
   localparam logic [ADDR_W-1:0] OFF_EXT = 8'hc0;
   localparam int EXT_SRC_POL_LSB = 0;
   localparam int EXT_DST_POL_LSB = 2;
   localparam int EXT_DRV_LSB = 4;

   // ----------------------------------------
   // Types and reset values
   // ----------------------------------------
   typedef struct packed {
      logic [HIER_N-1:0] pol;
      logic [HIER_N-1:0] byp;
      logic [HIER_N-1:0] trig0;
      logic [HIER_N-1:0] trig1;
      logic [HIER_N-1:0] ena;
   } oism_hcfg_t;
   localparam oism_hcfg_t RST_HCFG = '{pol: 8'hff, default: '0};
   localparam logic [1:0] RST_EXT_POL = 2'h3;
endpackage

// >>> oism_sticky.sv
/*
 Per-bit sticky flag with level or edge trigger and raw bypass.
 Assumes raw inputs are active high and synchronous to clk.
*/
`timescale 1ns/1ps
module oism_sticky #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Source and configuration
   input wire logic [W-1:0] raw,
   input wire logic [W-1:0] trig0,
   input wire logic [W-1:0] trig1,
   input wire logic [W-1:0] bypass,
   input wire logic [W-1:0] clear,
   input wire logic [W-1:0] force_set,
   // Results
   output logic [W-1:0] flag,
   output logic [W-1:0] hit,
   output logic [W-1:0] value
);
   import oism_pkg::*;

   typedef struct packed {
      logic [W-1:0] prev;
      logic [W-1:0] flag;
   } oism_stk_t;

   oism_stk_t st_q;
   oism_stk_t st_d;
   logic [W-1:0] set_v;

   for (genvar i = 0; i < W; i++)
   begin : g_bit
      logic [1:0] code;
      assign code = {trig1[i], trig0[i]};
      assign set_v[i] = (code == TRIG_LEVEL) ? raw[i] :
                        (code == TRIG_ANY) ? (raw[i] ^ st_q.prev[i]) :
                        (code == TRIG_FALL) ? (~raw[i] & st_q.prev[i]) :
                        (raw[i] & ~st_q.prev[i]); // R10
   end

   always_comb
   begin
      st_d = st_q;
      st_d.prev = raw;
      // Set beats clear so an event in the clearing cycle survives
      st_d.flag = (st_q.flag & ~clear) | set_v | force_set; // R11
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign flag = st_q.flag;
   assign hit = set_v | force_set;
   assign value = (bypass & raw) | (~bypass & st_q.flag); // R12
endmodule

// >>> oism_hier.sv
/*
 One serdes interrupt hierarchy folded into a single source request.
 Assumes the configuration is held by the register file of the parent.
*/
`timescale 1ns/1ps
module oism_hier (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Module requests and configuration
   input wire logic [oism_pkg::HIER_N-1:0] mod_irq,
   input wire oism_pkg::oism_hcfg_t cfg,
   input wire logic [oism_pkg::HIER_N-1:0] clear,
   // Status
   output logic [oism_pkg::HIER_N-1:0] raw,
   output logic [oism_pkg::HIER_N-1:0] flag,
   output logic [oism_pkg::HIER_N-1:0] ident,
   output logic aggregate
);
   import oism_pkg::*;

   logic [HIER_N-1:0] value;

   // Polarity one means active high
   assign raw = ~(mod_irq ^ cfg.pol); // R8

   oism_sticky #(
      .W(HIER_N)
   ) u_stk (
      .clk(clk),
      .sys_rst(sys_rst),
      .raw(raw),
      .trig0(cfg.trig0),
      .trig1(cfg.trig1),
      .bypass(cfg.byp),
      .clear(clear),
      .force_set('0),
      .flag(flag),
      .hit(),
      .value(value)
   );

   assign ident = value & cfg.ena;
   assign aggregate = |ident; // R1 R2
endmodule

// >>> oism_top.sv
/*
 Outbound interrupt source map: source vector, sticky logic, destination masks,
 external pins and register file.
 Assumes all inputs synchronous to clk and a master that never waits.
*/
`timescale 1ns/1ps
module oism_top (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [oism_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [oism_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [oism_pkg::DATA_W-1:0] reg_rdata,
   // Aggregated and hierarchy sources
   input wire logic port_module_irq,
   input wire logic [oism_pkg::HIER_N-1:0] serdes6_irq,
   input wire logic [oism_pkg::HIER_N-1:0] serdes10_irq,
   // External source pins
   input wire logic ext_source_zero,
   input wire logic ext_source_one,
   // Peripheral sources
   input wire logic card_wake_irq,
   input wire logic card_host_irq,
   input wire logic watchdog_irq,
   input wire logic timer_zero_irq,
   input wire logic timer_one_irq,
   input wire logic timer_two_irq,
   input wire logic uart_zero_irq,
   input wire logic uart_one_irq,
   input wire logic twi_zero_irq,
   input wire logic twi_one_irq,
   input wire logic serial_flash_master_irq,
   input wire logic sub_processor_lock_irq,
   input wire logic mailbox_soft_irq_zero,
   input wire logic mailbox_soft_irq_one,
   input wire logic serial_pin_irq_zero,
   input wire logic serial_pin_irq_one,
   input wire logic serial_pin_irq_two,
   input wire logic gpio_irq,
   input wire logic mgmt_ctrl_irq_zero,
   input wire logic mgmt_ctrl_irq_one,
   input wire logic mgmt_ctrl_irq_two,
   input wire logic mgmt_ctrl_irq_three,
   input wire logic frame_dma_irq,
   input wire logic analyzer_irq,
   input wire logic timestamp_ready_irq,
   input wire logic time_sync_irq,
   input wire logic mem_integrity_irq,
   input wire logic extraction_ready_irq,
   input wire logic injection_ready_irq,
   input wire logic pcie_irq,
   input wire logic egress_acl_irq,
   input wire logic rewriter_irq,
   input wire logic ddr_irq,
   input wire logic [9:0] shared_soft_irq,
   // Destination pins
   output logic ext_dest_zero,
   output logic ext_dest_zero_oe,
   output logic ext_dest_one,
   output logic ext_dest_one_oe,
   // Local interrupt
   output logic cpu_irq
);
   import oism_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [NSRC-1:0] byp;
      logic [NSRC-1:0] trig0;
      logic [NSRC-1:0] trig1;
      logic [NSRC-1:0] ena;
      logic [NSRC-1:0] map0;
      logic [NSRC-1:0] map1;
      oism_hcfg_t [1:0] hcfg;
      logic [1:0] src_pol;
      logic [1:0] dst_pol;
      logic [1:0] drv;
      logic [1:0] dst;
      logic [1:0] pin;
      logic [1:0] oe;
      logic irq;
      logic [DATA_W-1:0] rdata;
   } oism_state_t;

   oism_state_t st_q;
   oism_state_t st_d;

   logic [NSRC-1:0] src_v;
   logic [NSRC-1:0] m_flag;
   logic [NSRC-1:0] m_hit;
   logic [NSRC-1:0] m_value;
   logic [NSRC-1:0] m_ident;
   logic [NSRC-1:0] did0;
   logic [NSRC-1:0] did1;
   logic [NSRC-1:0] clr_v;
   logic [NSRC-1:0] frc_v;
   logic [1:0] ext_req;
   logic [1:0][HIER_N-1:0] h_mod;
   logic [1:0][HIER_N-1:0] h_clr;
   logic [1:0][HIER_N-1:0] h_raw;
   logic [1:0][HIER_N-1:0] h_flag;
   logic [1:0][HIER_N-1:0] h_ident;
   logic [1:0] h_agg;
   logic [ADDR_W-1:0] pa;
   logic [ADDR_W-1:0] wa;
   logic [ADDR_W-1:0] fa;
   logic hi;
   logic hidx;
   logic hreg;

   // ----------------------------------------
   // Word helpers for the 50-bit vectors
   // ----------------------------------------
   function automatic logic [NSRC-1:0] wr50(input logic [NSRC-1:0] v, input logic h,
                                            input logic [DATA_W-1:0] w);
      logic [NSRC-1:0] r;
      r = v;
      if (h)
      begin
         r[NSRC-1:DATA_W] = w[HI_W-1:0];
      end
      else
      begin
         r[DATA_W-1:0] = w;
      end
      return r;
   endfunction

   function automatic logic [DATA_W-1:0] rd50(input logic [NSRC-1:0] v, input logic h);
      return h ? {{(DATA_W-HI_W){1'h0}}, v[NSRC-1:DATA_W]} : v[DATA_W-1:0];
   endfunction

   // ----------------------------------------
   // Source vector
   // ----------------------------------------
   // Pins are corrected here so the core only sees active high
   assign ext_req = ~({ext_source_one, ext_source_zero} ^ st_q.src_pol); // R8
   assign h_mod[0] = serdes6_irq;
   assign h_mod[1] = serdes10_irq;

   for (genvar h = 0; h < 2; h++)
   begin : g_hier
      oism_hier u_hier (
         .clk(clk),
         .sys_rst(sys_rst),
         .mod_irq(h_mod[h]),
         .cfg(st_q.hcfg[h]),
         .clear(h_clr[h]),
         .raw(h_raw[h]),
         .flag(h_flag[h]),
         .ident(h_ident[h]),
         .aggregate(h_agg[h])
      );
   end

   // All positions active high from here on
   assign src_v = {shared_soft_irq, // R5
                   ddr_irq, rewriter_irq, egress_acl_irq, 1'h0, pcie_irq, // R4
                   injection_ready_irq, extraction_ready_irq, mem_integrity_irq, time_sync_irq, // R4
                   timestamp_ready_irq, analyzer_irq, frame_dma_irq, // R4
                   mgmt_ctrl_irq_three, mgmt_ctrl_irq_two, mgmt_ctrl_irq_one, mgmt_ctrl_irq_zero, // R4
                   gpio_irq, serial_pin_irq_two, serial_pin_irq_one, serial_pin_irq_zero, // R4
                   mailbox_soft_irq_one, mailbox_soft_irq_zero, // R5
                   sub_processor_lock_irq, serial_flash_master_irq, twi_one_irq, twi_zero_irq, // R4
                   uart_one_irq, uart_zero_irq, timer_two_irq, timer_one_irq, timer_zero_irq, // R4
                   watchdog_irq, card_host_irq, card_wake_irq, // R4
                   1'h0, ext_req, // R3
                   h_agg, port_module_irq}; // R7

   oism_sticky #(
      .W(NSRC)
   ) u_src (
      .clk(clk),
      .sys_rst(sys_rst),
      .raw(src_v),
      .trig0(st_q.trig0),
      .trig1(st_q.trig1),
      .bypass(st_q.byp),
      .clear(clr_v),
      .force_set(frc_v),
      .flag(m_flag),
      .hit(m_hit),
      .value(m_value)
   );

   // ----------------------------------------
   // Destination masks
   // ----------------------------------------
   assign m_ident = m_value & st_q.ena & SRC_USED; // R15
   assign did0 = m_ident & st_q.map0; // R13
   assign did1 = m_ident & st_q.map1; // R13

   // ----------------------------------------
   // Register file and next state
   // ----------------------------------------
   assign pa = reg_addr & PAIR_MASK;
   assign wa = reg_addr & WORD_MASK;
   assign fa = reg_addr & HFIELD_MASK;
   assign hi = reg_addr[HI_BIT];
   assign hidx = reg_addr[HIDX_BIT];
   assign hreg = (reg_addr & HREG_MASK) == HREG_BASE;

   always_comb
   begin
      st_d = st_q;
      st_d.rdata = '0;
      clr_v = '0;
      frc_v = '0;
      h_clr = '0;
      if (reg_wr)
      begin
         if (hreg)
         begin
            case (fa)
               HOFF_POL: st_d.hcfg[hidx].pol = reg_wdata[HIER_N-1:0];
               HOFF_BYP: st_d.hcfg[hidx].byp = reg_wdata[HIER_N-1:0];
               HOFF_TRIG0: st_d.hcfg[hidx].trig0 = reg_wdata[HIER_N-1:0];
               HOFF_TRIG1: st_d.hcfg[hidx].trig1 = reg_wdata[HIER_N-1:0];
               HOFF_STICKY: h_clr[hidx] = reg_wdata[HIER_N-1:0]; // R11
               HOFF_ENA: st_d.hcfg[hidx].ena = reg_wdata[HIER_N-1:0];
               default: ;
            endcase
         end
         else if (wa == OFF_EXT)
         begin
            st_d.src_pol = reg_wdata[EXT_SRC_POL_LSB +: 2];
            st_d.dst_pol = reg_wdata[EXT_DST_POL_LSB +: 2];
            st_d.drv = reg_wdata[EXT_DRV_LSB +: 2];
         end
         else
         begin
            case (pa)
               OFF_BYP: st_d.byp = wr50(st_q.byp, hi, reg_wdata);
               OFF_TRIG0: st_d.trig0 = wr50(st_q.trig0, hi, reg_wdata);
               OFF_TRIG1: st_d.trig1 = wr50(st_q.trig1, hi, reg_wdata);
               // Forcing an empty position would leave a set flag in the sticky read back
               OFF_FORCE: frc_v = wr50('0, hi, reg_wdata) & SRC_USED; // R15
               OFF_STICKY: clr_v = wr50('0, hi, reg_wdata); // R11
               OFF_ENA: st_d.ena = wr50(st_q.ena, hi, reg_wdata);
               OFF_MAP0: st_d.map0 = wr50(st_q.map0, hi, reg_wdata);
               OFF_MAP1: st_d.map1 = wr50(st_q.map1, hi, reg_wdata);
               default: ;
            endcase
         end
      end
      if (reg_rd)
      begin
         if (hreg)
         begin
            case (fa)
               HOFF_POL: st_d.rdata[HIER_N-1:0] = st_q.hcfg[hidx].pol;
               HOFF_RAW: st_d.rdata[HIER_N-1:0] = h_raw[hidx];
               HOFF_BYP: st_d.rdata[HIER_N-1:0] = st_q.hcfg[hidx].byp;
               HOFF_TRIG0: st_d.rdata[HIER_N-1:0] = st_q.hcfg[hidx].trig0;
               HOFF_TRIG1: st_d.rdata[HIER_N-1:0] = st_q.hcfg[hidx].trig1;
               HOFF_STICKY: st_d.rdata[HIER_N-1:0] = h_flag[hidx];
               HOFF_ENA: st_d.rdata[HIER_N-1:0] = st_q.hcfg[hidx].ena;
               HOFF_IDENT: st_d.rdata[HIER_N-1:0] = h_ident[hidx];
               default: ;
            endcase
         end
         else if (wa == OFF_EXT)
         begin
            st_d.rdata[EXT_SRC_POL_LSB +: 2] = st_q.src_pol;
            st_d.rdata[EXT_DST_POL_LSB +: 2] = st_q.dst_pol;
            st_d.rdata[EXT_DRV_LSB +: 2] = st_q.drv;
         end
         else
         begin
            case (pa)
               OFF_RAW: st_d.rdata = rd50(src_v, hi);
               OFF_BYP: st_d.rdata = rd50(st_q.byp, hi);
               OFF_TRIG0: st_d.rdata = rd50(st_q.trig0, hi);
               OFF_TRIG1: st_d.rdata = rd50(st_q.trig1, hi);
               OFF_STICKY: st_d.rdata = rd50(m_flag, hi);
               OFF_ENA: st_d.rdata = rd50(st_q.ena, hi);
               OFF_IDENT: st_d.rdata = rd50(m_ident, hi);
               OFF_MAP0: st_d.rdata = rd50(st_q.map0, hi);
               OFF_MAP1: st_d.rdata = rd50(st_q.map1, hi);
               OFF_DID0: st_d.rdata = rd50(did0, hi);
               OFF_DID1: st_d.rdata = rd50(did1, hi);
               default: ;
            endcase
         end
      end
      st_d.dst = {|did1, |did0}; // R14
      // Polarity one means active high on the pin
      st_d.pin = ~(st_d.dst ^ st_d.dst_pol); // R9
      // Open drain only drives while the destination is active
      st_d.oe = ~st_d.drv | st_d.dst; // R6
      st_d.irq = |m_ident;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_q <= '0;
         st_q.hcfg <= {2{RST_HCFG}};
         st_q.src_pol <= RST_EXT_POL;
         st_q.dst_pol <= RST_EXT_POL;
         st_q.oe <= 2'h3;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign reg_rdata = st_q.rdata;
   assign ext_dest_zero = st_q.pin[0]; // R6
   assign ext_dest_zero_oe = st_q.oe[0];
   assign ext_dest_one = st_q.pin[1]; // R6
   assign ext_dest_one_oe = st_q.oe[1];
   assign cpu_irq = st_q.irq;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   logic [NSRC-1:0] lvl_set;
   logic [NSRC-1:0] rise_set;
   logic [NSRC-1:0] clr_only;
   logic [NSRC-1:0] src_p;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         src_p <= '0;
      end
      else
      begin
         src_p <= src_v;
      end
   end

   assign lvl_set = src_v & ~st_q.trig0 & ~st_q.trig1;
   assign rise_set = src_v & ~src_p & st_q.trig0 & st_q.trig1;
   assign clr_only = clr_v & ~m_hit;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   s6_aggregate_a: assert property ((|(h_flag[0] & st_q.hcfg[0].ena & ~st_q.hcfg[0].byp)) |-> src_v[SRC_S6]) // R1
      else $error("serdes6 aggregate not raised");
   s10_aggregate_a: assert property ((|(h_raw[1] & st_q.hcfg[1].ena & st_q.hcfg[1].byp)) |-> src_v[SRC_S10]) // R2
      else $error("serdes10 aggregate not raised");
   ext_source_a: assert property (src_v[SRC_EXT1] == (ext_source_one ~^ st_q.src_pol[1]) && !src_v[SRC_RSVD]) // R3
      else $error("external source or reserved bit wrong");
   periph_place_a: assert property ({src_v[SRC_WDOG], src_v[SRC_DDR]} == {watchdog_irq, ddr_irq}) // R4
      else $error("peripheral source misplaced");
   soft_bits_a: assert property (src_v[NSRC-1:SRC_SOFT_LO] == shared_soft_irq && src_v[SRC_MBOX0] == mailbox_soft_irq_zero) // R5
      else $error("soft interrupt bits misplaced");
   level_set_a: assert property (lvl_set != 0 |=> (m_flag & $past(lvl_set)) == $past(lvl_set)) // R10
      else $error("level source did not set flag");
   rise_set_a: assert property (rise_set != 0 |=> (m_flag & $past(rise_set)) == $past(rise_set)) // R10
      else $error("rising edge did not set flag");
   clear_a: assert property (clr_only != 0 |=> (m_flag & $past(clr_only)) == 0) // R11
      else $error("flag not cleared by write of one");
   bypass_dst_a: assert property ((st_q.byp & src_v & st_q.ena & st_q.map0) != 0 |=> st_q.dst[0]) // R12
      else $error("bypassed source missed destination");
   map_gate_a: assert property ((st_q.ena & st_q.map1) == 0 |=> !st_q.dst[1]) // R13
      else $error("unmapped source reached destination");
   dest_or_a: assert property (st_q.dst[0] == $past(|(m_ident & st_q.map0))) // R14
      else $error("destination not raised");
   unused_zero_a: assert property ((m_flag & ~SRC_USED) == 0 && (m_ident & ~SRC_USED) == 0) // R15
      else $error("unassigned source active");
   pin_pol_a: assert property (st_q.pin == ~(st_q.dst ^ st_q.dst_pol)) // R9
      else $error("pin polarity wrong");
   pin_drive_a: assert property (st_q.drv == 2'h0 |-> st_q.oe == 2'h3) // R6
      else $error("push pull pin not driven");

   dst_seen_c: cover property (!st_q.dst[0] ##1 st_q.dst[0]);
   rise_seen_c: cover property (rise_set != 0 ##1 st_q.dst[1]);
   open_drain_c: cover property (st_q.drv[1] && st_q.oe[1] && !st_q.pin[1]);
   read_back_c: cover property (reg_rd ##1 reg_rdata != 0);
endmodule

// >>> oism_periph_model.sv
/*
 Peripheral side model: registers the wanted request vector onto the source lines.
 Assumes the bench sets want off the clock edge; every line is an active high level.
*/
`timescale 1ns/1ps
module oism_periph_model (
   // Clock and command
   input wire logic clk,
   input wire logic [49:0] want,
   // Source lines
   output logic [49:0] src
);
   // No polarity correction here, so want must already hold active high requests
   always_ff @(posedge clk) src <= want;
endmodule

// >>> test_outbound_interrupt_source_map.sv
/*
 Bench for the outbound interrupt source map.
 Assumes the peripheral model drives every source port from one vector.
*/
`timescale 1ns/1ps
`define CHK(n,e,a) begin n_compared++; if ((a)!==(e)) begin n_fail++; $display("ERROR %s exp %h got %h",n,e,a); end end
module test_outbound_interrupt_source_map;
   import oism_pkg::*;
   logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
   logic [7:0] reg_addr = 8'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
   logic [49:0] want = 50'h0, s;
   logic d0, d0oe, d1, d1oe, irq;
   int n_fail = 0, n_compared = 0;
   int rows [10][2] = '{'{1,1}, '{2,1}, '{3,1}, '{4,1}, '{5,0}, '{8,1}, '{18,1}, '{39,1}, '{45,1}, '{49,1}};
   oism_periph_model peri (.clk(clk), .want(want), .src(s));
   oism_top uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_module_irq(s[0]), .serdes6_irq({7'h0, s[1]}),
      .serdes10_irq({7'h0, s[2]}), .ext_source_zero(s[3]), .ext_source_one(s[4]), .card_wake_irq(s[6]),
      .card_host_irq(s[7]), .watchdog_irq(s[8]), .timer_zero_irq(s[9]), .timer_one_irq(s[10]),
      .timer_two_irq(s[11]), .uart_zero_irq(s[12]), .uart_one_irq(s[13]), .twi_zero_irq(s[14]),
      .twi_one_irq(s[15]), .serial_flash_master_irq(s[16]), .sub_processor_lock_irq(s[17]),
      .mailbox_soft_irq_zero(s[18]), .mailbox_soft_irq_one(s[19]), .serial_pin_irq_zero(s[20]),
      .serial_pin_irq_one(s[21]), .serial_pin_irq_two(s[22]), .gpio_irq(s[23]), .mgmt_ctrl_irq_zero(s[24]),
      .mgmt_ctrl_irq_one(s[25]), .mgmt_ctrl_irq_two(s[26]), .mgmt_ctrl_irq_three(s[27]),
      .frame_dma_irq(s[28]), .analyzer_irq(s[29]), .timestamp_ready_irq(s[30]), .time_sync_irq(s[31]),
      .mem_integrity_irq(s[32]), .extraction_ready_irq(s[33]), .injection_ready_irq(s[34]), .pcie_irq(s[35]),
      .egress_acl_irq(s[37]), .rewriter_irq(s[38]), .ddr_irq(s[39]), .shared_soft_irq(s[49:40]),
      .ext_dest_zero(d0), .ext_dest_zero_oe(d0oe), .ext_dest_one(d1), .ext_dest_one_oe(d1oe), .cpu_irq(irq));
   initial
   begin
      forever #5 clk = ~clk;
   end
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task w(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Hierarchy flags first, else a stale module flag re-raises sources 1 and 2
   task clr;
      wr(8'h94, 32'hff);
      wr(8'hb4, 32'hff);
      wr(OFF_STICKY, 32'hffffffff);
      wr(OFF_STICKY + 8'h4, 32'h3ffff);
   endtask
   task final_report;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      repeat (3000) @(posedge clk);
      n_fail++;
      final_report;
   end
   initial
   begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      `CHK("reset pins", 5'h0a, {d0, d0oe, d1, d1oe, irq})
      $display("reset test done");
      wr(OFF_ENA, 32'hffffffff);
      wr(OFF_ENA + 8'h4, 32'h3ffff);
      wr(OFF_MAP0, 32'hffffffff);
      wr(OFF_MAP0 + 8'h4, 32'h3ffff);
      wr(8'h98, 32'h1);
      wr(8'hb8, 32'h1);
      for (int i = 0; i < 10; i++)
      begin
         want <= 50'h1 << rows[i][0];
         w(5);
         rd(OFF_STICKY + 8'(4 * (rows[i][0] / 32)));
         `CHK("flag", rows[i][1][0], d[rows[i][0] % 32])
         `CHK("dest0", rows[i][1][0], d0)
         want <= 50'h0;
         w(3);
         clr;
         w(3);
         `CHK("cleared", 1'b0, irq)
      end
      $display("source rows done");
      wr(OFF_FORCE, 32'hffffffff);
      wr(OFF_FORCE + 8'h4, 32'h3ffff);
      rd(OFF_STICKY);
      `CHK("rsvd5", 1'b0, d[5])
      rd(OFF_STICKY + 8'h4);
      `CHK("rsvd36", 1'b0, d[4])
      rd(8'hfc);
      `CHK("unmapped", 32'h0, d)
      clr;
      want <= 50'h100;
      w(4);
      clr;
      rd(OFF_STICKY);
      `CHK("level reset", 1'b1, d[8])
      wr(OFF_MAP0 + 8'h4, 32'h0);
      w(3);
      `CHK("map", 3'h5, {d0, d1, irq})
      wr(OFF_MAP1, 32'h100);
      w(3);
      `CHK("map1", 1'b1, d1)
      wr(OFF_ENA, 32'h0);
      w(3);
      `CHK("masked", 3'h0, {d0, d1, irq})
      wr(OFF_EXT, 32'h13);
      w(3);
      `CHK("od idle", 2'h2, {d0, d0oe})
      wr(OFF_ENA, 32'hffffffff);
      w(3);
      `CHK("dst pol", 2'h1, {d0, d0oe})
      wr(OFF_EXT, 32'hf);
      want <= 50'h0;
      w(3);
      clr;
      wr(OFF_BYP, 32'h100);
      want <= 50'h100;
      w(3);
      `CHK("bypass up", 1'b1, d0)
      want <= 50'h0;
      w(3);
      `CHK("bypass down", 1'b0, d0)
      $display("map tests done");
      wr(OFF_BYP, 32'h0);
      for (int c = 1; c < 4; c++)
      begin
         wr(OFF_TRIG0, c[0] ? 32'h100 : 32'h0);
         wr(OFF_TRIG1, c[1] ? 32'h100 : 32'h0);
         clr;
         want <= 50'h100;
         w(3);
         rd(OFF_STICKY);
         `CHK("rise", c != 2, d[8])
         clr;
         want <= 50'h0;
         w(3);
         rd(OFF_STICKY);
         `CHK("fall", c != 3, d[8])
      end
      wr(8'ha8, 32'h1);
      want <= 50'h4;
      w(4);
      rd(8'hbc);
      `CHK("hier bypass", 1'b1, d[0])
      want <= 50'h0;
      w(3);
      rd(8'hbc);
      `CHK("hier drop", 1'b0, d[0])
      $display("edge tests done");
      final_report;
   end
endmodule
